// ---- inc/ctrl_flow_pkg.sv ----
`default_nettype none

package ctrl_flow_pkg;

    // primary opcodes
    localparam logic [5:0] OP_CALL = 6'h00;
    localparam logic [5:0] OP_BRANCH_ALWAYS = 6'h06;
    localparam logic [5:0] OP_BNE = 6'h1e;
    localparam logic [5:0] OP_RTYPE = 6'h3a;

    // extended opcodes of the register-form group
    localparam logic [5:0] OPX_BRET = 6'h09;
    localparam logic [5:0] OPX_CALLR = 6'h1d;
    localparam logic [5:0] OPX_BREAK = 6'h34;
    localparam logic [5:0] OPX_CMPEQ_DEFAULT = 6'h20;

    // fixed register indices
    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam logic [4:0] REG_BA = 5'h1e;
    localparam logic [4:0] REG_RETURN_ADDR = 5'h1f;

    // status register bit positions
    localparam int STATUS_INTR_ENABLE_BIT = 0;
    localparam int STATUS_U_BIT = 1;

    // value is arbitrary, the real address is set per core
    localparam logic [31:0] BREAK_HANDLER_DEFAULT = 32'h0000_0020;

    localparam logic [31:0] PC_STEP = 32'h0000_0004;

    typedef struct packed {
        logic [4:0] srcRegA;
        logic [4:0] srcRegB;
        logic [4:0] destRegC;
        logic [5:0] opx;
        logic [4:0] bpTypeField;
        logic [5:0] op;
    } rtype_t;

    typedef struct packed {
        logic [4:0] srcRegA;
        logic [4:0] srcRegB;
        logic [15:0] offset16Field;
        logic [5:0] op;
    } itype_t;

    typedef struct packed {
        logic [25:0] target26Field;
        logic [5:0] op;
    } jtype_t;

    typedef struct packed {
        logic done;
        logic squashed;
        logic claimed;
        logic redirect;
        logic [31:0] nextPc;
        logic regWe;
        logic [4:0] regIdx;
        logic [31:0] regData;
        logic statusWe;
        logic [31:0] statusData;
        logic bstatusWe;
        logic [31:0] bstatusData;
        logic excMisalign;
        logic excSuper;
        logic excBreak;
    } result_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SQUASH = 2'b10
    } flow_state_t;

endpackage : ctrl_flow_pkg

`default_nettype wire

// ---- hdl/pc_target_calc.sv ----
`timescale 1ns/1ps
`default_nettype none

module pc_target_calc #(
    parameter int W = 32
) (
    // operands
    input wire logic [W-1:0] pcCur,
    input wire logic [15:0] offset16,
    // results
    output logic [W-1:0] seqPc,
    output logic [W-1:0] relTarget,
    output logic relMisaligned
);

    logic [W-1:0] offsetExt;

    // byte displacement, no scaling, measured from the following word
    assign offsetExt = {{(W-16){offset16[15]}}, offset16};
    assign seqPc = pcCur + W'(ctrl_flow_pkg::PC_STEP);
    assign relTarget = seqPc + offsetExt;
    assign relMisaligned = |relTarget[1:0];

endmodule : pc_target_calc

`default_nettype wire

// ---- hdl/ctrl_flow_insn_decode_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

module ctrl_flow_insn_decode_exec #(
    parameter logic [31:0] BREAK_HANDLER_ADDR = ctrl_flow_pkg::BREAK_HANDLER_DEFAULT,
    parameter logic [5:0] CMPEQ_OPX = ctrl_flow_pkg::OPX_CMPEQ_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // issued instruction and its operands
    input wire logic insnValid,
    input wire logic [31:0] insnWord,
    input wire logic [31:0] pcCur,
    input wire logic [31:0] srcValA,
    input wire logic [31:0] srcValB,
    // control registers as currently held
    input wire logic [31:0] statusCur,
    input wire logic [31:0] bstatusCur,
    // executed result
    output ctrl_flow_pkg::result_t result
);

    ctrl_flow_pkg::rtype_t rIns;
    ctrl_flow_pkg::itype_t iIns;
    ctrl_flow_pkg::jtype_t jIns;
    ctrl_flow_pkg::flow_state_t flowState_r;
    ctrl_flow_pkg::flow_state_t flowState_nxt;
    ctrl_flow_pkg::result_t result_r;
    ctrl_flow_pkg::result_t result_nxt;

    logic accept;
    logic isBne;
    logic isBranchAlways;
    logic isBreak;
    logic isBret;
    logic isCall;
    logic isCallr;
    logic isCmpeq;
    logic operandsDiffer;
    logic userMode;
    logic indirectMisaligned;
    logic [31:0] seqPc;
    logic [31:0] relTarget;
    logic relMisaligned;
    logic [31:0] breakStatus;

    assign rIns = ctrl_flow_pkg::rtype_t'(insnWord);
    assign iIns = ctrl_flow_pkg::itype_t'(insnWord);
    assign jIns = ctrl_flow_pkg::jtype_t'(insnWord);

    // a successor already fetched behind a transfer is dropped here
    assign accept = insnValid && (flowState_r == ctrl_flow_pkg::ST_RUN);

    assign isBne = (iIns.op == ctrl_flow_pkg::OP_BNE);
    assign isBranchAlways = (iIns.op == ctrl_flow_pkg::OP_BRANCH_ALWAYS)
        && (iIns.srcRegA == ctrl_flow_pkg::REG_ZERO)
        && (iIns.srcRegB == ctrl_flow_pkg::REG_ZERO);
    // type field left out of the match, the debugger owns it
    assign isBreak = (rIns.op == ctrl_flow_pkg::OP_RTYPE)
        && (rIns.opx == ctrl_flow_pkg::OPX_BREAK)
        && (rIns.srcRegA == ctrl_flow_pkg::REG_ZERO)
        && (rIns.srcRegB == ctrl_flow_pkg::REG_ZERO)
        && (rIns.destRegC == ctrl_flow_pkg::REG_BA);
    assign isBret = (rIns.op == ctrl_flow_pkg::OP_RTYPE)
        && (rIns.opx == ctrl_flow_pkg::OPX_BRET)
        && (rIns.srcRegA == ctrl_flow_pkg::REG_BA)
        && (rIns.srcRegB == ctrl_flow_pkg::REG_ZERO)
        && (rIns.destRegC == ctrl_flow_pkg::REG_BA);
    assign isCall = (jIns.op == ctrl_flow_pkg::OP_CALL);
    assign isCallr = (rIns.op == ctrl_flow_pkg::OP_RTYPE)
        && (rIns.opx == ctrl_flow_pkg::OPX_CALLR)
        && (rIns.srcRegB == ctrl_flow_pkg::REG_ZERO)
        && (rIns.destRegC == ctrl_flow_pkg::REG_RETURN_ADDR);
    assign isCmpeq = (rIns.op == ctrl_flow_pkg::OP_RTYPE) && (rIns.opx == CMPEQ_OPX);

    assign operandsDiffer = (srcValA != srcValB);
    assign userMode = statusCur[ctrl_flow_pkg::STATUS_U_BIT];
    assign indirectMisaligned = |srcValA[1:0];

    // interrupts off and back in supervisor mode on entry to the handler
    always_comb
    begin
        breakStatus = statusCur;
        breakStatus[ctrl_flow_pkg::STATUS_INTR_ENABLE_BIT] = 1'b0;
        breakStatus[ctrl_flow_pkg::STATUS_U_BIT] = 1'b0;
    end

    pc_target_calc #(
        .W(32)
    ) pc_target_calc_inst (
        .pcCur(pcCur),
        .offset16(iIns.offset16Field),
        .seqPc(seqPc),
        .relTarget(relTarget),
        .relMisaligned(relMisaligned)
    );

    always_comb
    begin
        result_nxt = '0;
        result_nxt.nextPc = seqPc;
        result_nxt.done = accept;
        result_nxt.squashed = insnValid && !accept;
        if (accept)
        begin
            if (isBne)
            begin
                result_nxt.claimed = 1'b1;
                if (operandsDiffer)
                begin
                    if (relMisaligned)
                    begin
                        result_nxt.excMisalign = 1'b1;
                    end
                    else
                    begin
                        result_nxt.redirect = 1'b1;
                        result_nxt.nextPc = relTarget;
                    end
                end
            end
            else if (isBranchAlways)
            begin
                result_nxt.claimed = 1'b1;
                if (relMisaligned)
                begin
                    result_nxt.excMisalign = 1'b1;
                end
                else
                begin
                    result_nxt.redirect = 1'b1;
                    result_nxt.nextPc = relTarget;
                end
            end
            else if (isBreak)
            begin
                result_nxt.claimed = 1'b1;
                result_nxt.excBreak = 1'b1;
                result_nxt.bstatusWe = 1'b1;
                result_nxt.bstatusData = statusCur;
                result_nxt.statusWe = 1'b1;
                result_nxt.statusData = breakStatus;
                result_nxt.regWe = 1'b1;
                result_nxt.regIdx = ctrl_flow_pkg::REG_BA;
                result_nxt.regData = seqPc;
                result_nxt.redirect = 1'b1;
                result_nxt.nextPc = BREAK_HANDLER_ADDR;
            end
            else if (isBret)
            begin
                result_nxt.claimed = 1'b1;
                if (userMode)
                begin
                    result_nxt.excSuper = 1'b1;
                end
                else if (indirectMisaligned)
                begin
                    result_nxt.excMisalign = 1'b1;
                end
                else
                begin
                    result_nxt.statusWe = 1'b1;
                    result_nxt.statusData = bstatusCur;
                    result_nxt.redirect = 1'b1;
                    result_nxt.nextPc = srcValA;
                end
            end
            else if (isCall)
            begin
                // no fault possible: the target is word aligned by construction
                result_nxt.claimed = 1'b1;
                result_nxt.regWe = 1'b1;
                result_nxt.regIdx = ctrl_flow_pkg::REG_RETURN_ADDR;
                result_nxt.regData = seqPc;
                result_nxt.redirect = 1'b1;
                result_nxt.nextPc = {pcCur[31:28], jIns.target26Field, 2'b00};
            end
            else if (isCallr)
            begin
                result_nxt.claimed = 1'b1;
                if (indirectMisaligned)
                begin
                    result_nxt.excMisalign = 1'b1;
                end
                else
                begin
                    result_nxt.regWe = 1'b1;
                    result_nxt.regIdx = ctrl_flow_pkg::REG_RETURN_ADDR;
                    result_nxt.regData = seqPc;
                    result_nxt.redirect = 1'b1;
                    result_nxt.nextPc = srcValA;
                end
            end
            else if (isCmpeq)
            begin
                result_nxt.claimed = 1'b1;
                result_nxt.regWe = 1'b1;
                result_nxt.regIdx = rIns.destRegC;
                result_nxt.regData = {31'h0000_0000, !operandsDiffer};
            end
        end
    end

    // squash also follows a fault, the exception controller refetches
    always_comb
    begin
        flowState_nxt = flowState_r;
        case (flowState_r)
            ctrl_flow_pkg::ST_RUN:
            begin
                if (result_nxt.redirect || result_nxt.excMisalign || result_nxt.excSuper)
                begin
                    flowState_nxt = ctrl_flow_pkg::ST_SQUASH;
                end
            end
            ctrl_flow_pkg::ST_SQUASH:
            begin
                if (insnValid)
                begin
                    flowState_nxt = ctrl_flow_pkg::ST_RUN;
                end
            end
            default:
            begin
                flowState_nxt = ctrl_flow_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            flowState_r <= ctrl_flow_pkg::ST_RUN;
        end
        else
        begin
            flowState_r <= flowState_nxt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            result_r <= '0;
        end
        else
        begin
            result_r <= result_nxt;
        end
    end

    assign result = result_r;

    a_bne_taken_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isBne && operandsDiffer && !relMisaligned
        |=> result.redirect && result.nextPc == $past(pcCur) + 32'h0000_0004
            + {{16{$past(insnWord[21])}}, $past(insnWord[21:6])})
        else $error("bne taken target wrong");

    a_bne_fall_through: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isBne && !operandsDiffer
        |=> !result.redirect && !result.excMisalign && result.nextPc == $past(pcCur) + 32'h0000_0004)
        else $error("bne not taken must step by four");

    a_misalign_blocks_jump: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && (isBranchAlways || (isBne && operandsDiffer)) && relMisaligned
        |=> result.excMisalign && !result.redirect)
        else $error("misaligned relative target not faulted");

    a_branch_always_goes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isBranchAlways && !relMisaligned
        |=> result.redirect && result.nextPc == $past(relTarget))
        else $error("unconditional branch did not redirect");

    a_break_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isBreak
        |=> result.excBreak && result.bstatusData == $past(statusCur)
            && result.statusData[1:0] == 2'b00 && result.regIdx == 5'h1e
            && result.regData == $past(pcCur) + 32'h0000_0004 && result.nextPc == BREAK_HANDLER_ADDR)
        else $error("break entry effects wrong");

    a_bret_user_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isBret && userMode
        |=> result.excSuper && !result.statusWe && !result.redirect)
        else $error("bret in user mode not refused");

    a_bret_restore: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isBret && !userMode && !indirectMisaligned
        |=> result.statusWe && result.statusData == $past(bstatusCur) && result.nextPc == $past(srcValA))
        else $error("bret did not restore and resume");

    a_call_region: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isCall
        |=> result.nextPc[31:28] == $past(pcCur[31:28]) && result.nextPc[27:2] == $past(insnWord[31:6])
            && result.regIdx == 5'h1f && !result.excMisalign)
        else $error("call target or link wrong");

    a_callr_link: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isCallr && !indirectMisaligned
        |=> result.regWe && result.regIdx == 5'h1f && result.nextPc == $past(srcValA))
        else $error("callr link or target wrong");

    a_cmpeq_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && isCmpeq
        |=> result.regWe && result.regData == {31'h0000_0000, $past(srcValA) == $past(srcValB)})
        else $error("cmpeq result wrong");

    a_successor_squash: assert property (@(posedge clk_sys) disable iff (!rst_n)
        result.redirect && insnValid
        |=> result.squashed && !result.done && !result.regWe)
        else $error("successor of a transfer not squashed");

    a_indirect_misalign: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && (isCallr || (isBret && !userMode)) && indirectMisaligned
        |=> result.excMisalign && !result.redirect && !result.regWe && !result.statusWe)
        else $error("misaligned indirect target not faulted");

    a_unclaimed_inert: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !(isBne || isBranchAlways || isBreak || isBret || isCall || isCallr || isCmpeq)
        |=> result.done && !result.claimed && !result.redirect && !result.regWe && !result.statusWe)
        else $error("foreign word had effects");

endmodule : ctrl_flow_insn_decode_exec

`default_nettype wire

// ---- dv/ctrl_flow_insn_decode_exec_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module ctrl_flow_insn_decode_exec_bench;
    localparam logic [31:0] HANDLER = 32'h0000_0140;
    localparam logic [5:0] CMPEQ = ctrl_flow_pkg::OPX_CMPEQ_DEFAULT;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic insnValid = 1'b0;
    logic [31:0] insnWord = '0;
    logic [31:0] pcCur = '0;
    logic [31:0] srcValA = '0;
    logic [31:0] srcValB = '0;
    logic [31:0] statusCur = '0;
    logic [31:0] bstatusCur = '0;
    ctrl_flow_pkg::result_t result;
    ctrl_flow_pkg::result_t notes[$];
    logic [31:0] seed = 32'h0000_0729;
    // next live word is dropped after any transfer or fault
    logic shadow = 1'b0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    ctrl_flow_insn_decode_exec #(
        .BREAK_HANDLER_ADDR(HANDLER),
        .CMPEQ_OPX(CMPEQ)
    ) ctrl_flow_insn_decode_exec_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .insnValid(insnValid),
        .insnWord(insnWord),
        .pcCur(pcCur),
        .srcValA(srcValA),
        .srcValB(srcValB),
        .statusCur(statusCur),
        .bstatusCur(bstatusCur),
        .result(result)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic ctrl_flow_pkg::result_t model(logic [31:0] w, logic [31:0] pc, logic [31:0] a,
        logic [31:0] b, logic [31:0] st, logic [31:0] bst);
        ctrl_flow_pkg::result_t e;
        logic [31:0] tgt;
        logic xfer;
        e = '0;
        e.done = 1'b1;
        e.claimed = 1'b1;
        e.nextPc = pc + 32'h0000_0004;
        tgt = pc + 32'h0000_0004 + {{16{w[21]}}, w[21:6]};
        xfer = 1'b1;
        e.regData = pc + 32'h0000_0004;
        if (w[5:0] == 6'h1e)
            xfer = (a != b);
        else if (w[5:0] == 6'h00)
        begin
            tgt = {pc[31:28], w[31:6], 2'b00};
            e.regWe = 1'b1;
            e.regIdx = 5'h1f;
        end
        else if (w[5:0] == 6'h3a && w[16:11] == 6'h34)
        begin
            tgt = HANDLER;
            e.excBreak = 1'b1;
            e.bstatusWe = 1'b1;
            e.bstatusData = st;
            e.statusWe = 1'b1;
            e.statusData = st;
            e.statusData[ctrl_flow_pkg::STATUS_INTR_ENABLE_BIT] = 1'b0;
            e.statusData[ctrl_flow_pkg::STATUS_U_BIT] = 1'b0;
            e.regWe = 1'b1;
            e.regIdx = 5'h1e;
        end
        else if (w[5:0] == 6'h3a && w[16:11] == 6'h09)
        begin
            tgt = a;
            e.statusWe = 1'b1;
            e.statusData = bst;
            e.excSuper = st[ctrl_flow_pkg::STATUS_U_BIT];
        end
        else if (w[5:0] == 6'h3a && w[16:11] == 6'h1d)
        begin
            tgt = a;
            e.regWe = 1'b1;
            e.regIdx = 5'h1f;
        end
        else if (w[5:0] == 6'h3a && w[16:11] == CMPEQ)
        begin
            xfer = 1'b0;
            e.regWe = 1'b1;
            e.regIdx = w[21:17];
            e.regData = {31'h0, a == b};
        end
        else if (w[5:0] != 6'h06)
        begin
            xfer = 1'b0;
            e.claimed = 1'b0;
        end
        if (e.claimed == 1'b0)
            e.regWe = 1'b0;
        if (e.excSuper || (xfer && tgt[1:0] != 2'b00))
        begin
            e.excMisalign = !e.excSuper;
            e.regWe = 1'b0;
            e.statusWe = 1'b0;
        end
        else if (xfer)
        begin
            e.redirect = 1'b1;
            e.nextPc = tgt;
        end
        return e;
    endfunction : model

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_res(ctrl_flow_pkg::result_t e, ctrl_flow_pkg::result_t g);
        check("done", e.done, g.done);
        check("squashed", e.squashed, g.squashed);
        check("exceptions", {e.excMisalign, e.excSuper, e.excBreak}, {g.excMisalign, g.excSuper, g.excBreak});
        check("writes", {e.regWe, e.statusWe, e.bstatusWe}, {g.regWe, g.statusWe, g.bstatusWe});
        if (e.regWe)
            check("reg write", {e.regIdx, e.regData[26:0]}, {g.regIdx, g.regData[26:0]});
        if (e.regWe)
            check("reg data", e.regData, g.regData);
        if (e.statusWe)
            check("status data", e.statusData, g.statusData);
        if (e.bstatusWe)
            check("bstatus data", e.bstatusData, g.bstatusData);
        if (!e.squashed)
            check("claimed", e.claimed, g.claimed);
        if (!(e.squashed || e.excMisalign || e.excSuper))
            check("redirect", e.redirect, g.redirect);
        if (!e.squashed)
            check("next pc", e.nextPc, g.nextPc);
    endtask : check_res

    always @(posedge clk_sys)
    begin
        #1;
        if (rst_n && ((result.done | result.squashed) === 1'b1))
        begin
            if (notes.size() == 0)
                check("unexpected result", 32'h0, 32'h1);
            else
                check_res(notes.pop_front(), result);
        end
    end

    task automatic issue(logic [31:0] w, logic [31:0] a, logic [31:0] b, logic [31:0] st);
        ctrl_flow_pkg::result_t e;
        logic [31:0] pc;
        logic [31:0] bst;
        pc = rnd() & 32'hffff_fffc;
        bst = rnd();
        @(negedge clk_sys);
        e = model(w, pc, a, b, st, bst);
        if (shadow)
        begin
            e = '0;
            e.squashed = 1'b1;
        end
        shadow = !shadow && (e.redirect || e.excMisalign || e.excSuper);
        notes.push_back(e);
        insnValid = 1'b1;
        insnWord = w;
        pcCur = pc;
        srcValA = a;
        srcValB = b;
        statusCur = st;
        bstatusCur = bst;
    endtask : issue

    task automatic idle();
        @(negedge clk_sys);
        insnValid = 1'b0;
        insnWord = rnd();
        srcValA = rnd();
    endtask : idle

    task automatic run_mix(int n, bit gaps);
        logic [31:0] r;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] w;
        logic [15:0] off;
        for (int i = 0; i < n; i++)
        begin
            r = rnd();
            a = rnd();
            if (r[6])
                a[1:0] = 2'b00;
            b = r[7] ? a : rnd();
            // odd offsets are rare, to reach the fault path now and then
            off = {r[23:10], r[9:8] == 2'b00 ? r[1:0] : 2'b00};
            case (r[30:28])
                3'd0: w = {r[31:22], off, 6'h1e};
                3'd1: w = {10'h000, off, 6'h06};
                3'd2: w = {10'h000, 5'h1e, 6'h34, r[4:0], 6'h3a};
                3'd3: w = {5'h1e, 5'h00, 5'h1e, 6'h09, 5'h00, 6'h3a};
                3'd4: w = {r[25:0], 6'h00};
                3'd5: w = {r[31:27], 5'h00, 5'h1f, 6'h1d, 5'h00, 6'h3a};
                3'd6: w = {r[31:17], CMPEQ, 5'h00, 6'h3a};
                default: w = r[27] ? {r[31:6], 6'h16} : {r[31:17], 6'h08, 5'h00, 6'h3a};
            endcase
            issue(w, a, b, rnd());
            if (gaps && r[5])
                idle();
        end
        idle();
        repeat (3) @(negedge clk_sys);
        check("pending results", 32'h0, notes.size());
    endtask : run_mix

    task automatic do_reset();
        ctrl_flow_pkg::result_t r;
        @(negedge clk_sys);
        rst_n = 1'b0;
        insnValid = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("result under reset", 32'h1, {31'h0, result === '0});
        notes.delete();
        shadow = 1'b0;
        rst_n = 1'b1;
        @(posedge clk_sys);
        #1;
        r = result;
        // next pc follows the held pcCur input, only the effects must be clear
        r.nextPc = '0;
        check("result after reset", 32'h1, {31'h0, r === '0});
        check("next pc after reset", pcCur + 32'h0000_0004, result.nextPc);
    endtask : do_reset

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            $display("[FAIL] cycle limit expected below %0d seen %0d", 5000, cycles);
            wrap_up();
        end
    end

    initial
    begin
        do_reset();
        $display("test reset done");
        run_mix(150, 1'b1);
        $display("test mixed with gaps done");
        run_mix(150, 1'b0);
        $display("test back to back done");
        issue({10'h000, 5'h1e, 6'h34, 5'h00, 6'h3a}, rnd(), rnd(), rnd());
        do_reset();
        run_mix(30, 1'b0);
        $display("test reset in mid-run done");
        wrap_up();
    end
endmodule : ctrl_flow_insn_decode_exec_bench

`default_nettype wire
